// >>> rtl/gpio_pkg.sv
// Package with register map, field widths and reset values for the GPIO ports.
package gpio_pkg;

	// ****************************************************************
	// Register word indices and byte addresses
	// ****************************************************************
	// Each register takes one aligned word, so its byte address is four times its index.
	localparam logic [9:0] IDX_PORT_B_DATA = 10'h001;
	localparam logic [9:0] IDX_PORT_C_DATA = 10'h002;
	localparam logic [9:0] IDX_PORT_A_DIRECTION = 10'h004;
	localparam logic [9:0] IDX_PORT_B_DIRECTION = 10'h005;
	localparam logic [9:0] IDX_PORT_C_DIRECTION = 10'h006;
	localparam logic [9:0] IDX_PORT_A_PULLUP_ENABLE = 10'h00d;
	localparam logic [9:0] IDX_PORT_C_PULLUP_ENABLE = 10'h00e;
	localparam logic [9:0] IDX_ANALOG_SELECT = 10'h010;
	localparam logic [11:0] ADDR_PORT_B_DATA = {IDX_PORT_B_DATA, 2'b00};
	localparam logic [11:0] ADDR_PORT_C_DATA = {IDX_PORT_C_DATA, 2'b00};
	localparam logic [11:0] ADDR_PORT_A_PULLUP_ENABLE = {IDX_PORT_A_PULLUP_ENABLE, 2'b00};
	localparam logic [11:0] ADDR_PORT_B_DIRECTION = {IDX_PORT_B_DIRECTION, 2'b00};
	localparam logic [11:0] ADDR_PORT_C_DIRECTION = {IDX_PORT_C_DIRECTION, 2'b00};
	localparam logic [11:0] ADDR_PORT_A_DIRECTION = {IDX_PORT_A_DIRECTION, 2'b00};
	localparam logic [11:0] ADDR_PORT_C_PULLUP_ENABLE = {IDX_PORT_C_PULLUP_ENABLE, 2'b00};
	localparam logic [11:0] ADDR_ANALOG_SELECT = {IDX_ANALOG_SELECT, 2'b00};

	// ****************************************************************
	// Widths and reset values
	// ****************************************************************
	localparam int PORT_W = 8;
	localparam int PORT_C_W = 7;
	localparam logic [7:0] DIRECTION_RESET = 8'h00;
	localparam logic [7:0] PULLUP_RESET = 8'h00;
	localparam logic [4:0] ANALOG_CHANNEL_NONE = 5'h1f;
	localparam logic [4:0] ANALOG_SELECT_RESET = 5'h1f;

	typedef enum logic [1:0] {
		st_idle,
		st_access
	} apb_state_t;

endpackage

// >>> rtl/gpio_pin_slice.sv
// One port's pin drive, pullup gating and read-back mux.
`timescale 1ns/1ns
module gpio_pin_slice
	import gpio_pkg::*;
#(
	parameter int W = 8
)
(
	// Control
	input wire logic [W-1:0] latch,
	input wire logic [W-1:0] direction,
	input wire logic [W-1:0] pullup_enable,
	input wire logic [W-1:0] analog_force,
	// Pins
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] drive_value,
	output logic [W-1:0] drive_enable,
	output logic [W-1:0] pullup_on,
	output logic [W-1:0] read_value
);

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			// An analog-selected pin loses driver and pullup regardless of control bits.
			assign drive_enable[i] = direction[i] & ~analog_force[i];
			assign drive_value[i] = latch[i];
			assign pullup_on[i] = pullup_enable[i] & ~direction[i] & ~analog_force[i];
			assign read_value[i] = direction[i] ? latch[i] : pin_in[i];
		end
	endgenerate

endmodule

// >>> rtl/analog_select_decode.sv
// Decoder from the converter channel number to a one-hot port B pin mask, all zero for channels 8 and up.
`timescale 1ns/1ns
module analog_select_decode
	import gpio_pkg::*;
(
	// Channel
	input wire logic [4:0] channel,
	// Mask
	output logic [7:0] mask
);

	always_comb
	begin
		mask = 8'h00;
		if (channel < 5'h08)
		begin
			mask[channel[2:0]] = 1'b1;
		end
	end

endmodule

// >>> rtl/gpio_ports_a_b_c.sv
// Top of the port A pullup, port B and port C GPIO block with an APB slave.
//
// Function
// - Port A pullup per pin, active only while that pin is input.
// - Port A pullup bit one connects pullup, zero disconnects it.
// - Port A pullup bits are independent and gated by port A direction.
// - Port B data holds eight read/write latches untouched by reset.
// - Selected analog channel forces its port B pin to analog input.
// - Unselected port B pins behave as ordinary digital I/O.
// - Port B direction one enables driver, zero leaves pin high impedance.
// - Reset clears all port B direction bits.
// - Port B read returns latch for outputs, pin level for inputs.
// - Data writes with pstrb[0] set update latches in either direction; input read-back stays the pin.
// - Port C has seven read/write latches kept through reset.
// - Port C direction one drives, zero inputs; reset clears all seven.
// - Port C read returns latch for outputs, pin level for inputs.
// - Port C input with pullup enabled is pulled up, else high impedance.
// - Port A pullup register resets to zero and is fully read/write.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module gpio_ports_a_b_c
	import gpio_pkg::*;
(
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog converter channel select
	input wire logic [4:0] analog_channel,
	// Port A pullup control
	input wire logic [7:0] port_a_direction,
	output logic [7:0] port_a_pullup_on,
	// Port B pins
	input wire logic [7:0] port_b_in,
	output logic [7:0] port_b_out,
	output logic [7:0] port_b_oe,
	output logic [7:0] analog_channel_pins,
	// Port C pins
	input wire logic [6:0] port_c_in,
	output logic [6:0] port_c_out,
	output logic [6:0] port_c_oe,
	output logic [6:0] port_c_pullup_on
);

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Data latches have no reset; they power up unknown as the silicon does.
	logic [7:0] port_b_data_q, port_b_data_d;
	logic [6:0] port_c_data_q, port_c_data_d;
	logic [7:0] port_a_pullup_enable_q, port_a_pullup_enable_d;
	logic [7:0] port_b_direction_q, port_b_direction_d;
	logic [6:0] port_c_direction_q, port_c_direction_d;
	logic [6:0] port_c_pullup_enable_q, port_c_pullup_enable_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	apb_state_t state_q, state_d;

	// Pin outputs are registered so every top output comes from a flip-flop.
	logic [7:0] pa_pull_q, pb_out_q, pb_oe_q, pb_ana_q;
	logic [6:0] pc_out_q, pc_oe_q, pc_pull_q;

	// ****************************************************************
	// Pin logic
	// ****************************************************************
	logic [7:0] analog_mask;
	logic [7:0] pb_drv, pb_en, pb_pull, pb_rd;
	logic [6:0] pc_drv, pc_en, pc_pull, pc_rd;
	logic [7:0] pa_drv, pa_en, pa_pull, pa_rd;

	analog_select_decode u_decode (
		.channel(analog_channel),
		.mask(analog_mask)
	);

	// Port A only uses the pullup gating here.
	gpio_pin_slice #(.W(8)) u_port_a (
		.latch(8'h00),
		.direction(port_a_direction),
		.pullup_enable(port_a_pullup_enable_q),
		.analog_force(8'h00),
		.pin_in(8'h00),
		.drive_value(pa_drv),
		.drive_enable(pa_en),
		.pullup_on(pa_pull),
		.read_value(pa_rd)
	);

	gpio_pin_slice #(.W(8)) u_port_b (
		.latch(port_b_data_q),
		.direction(port_b_direction_q),
		.pullup_enable(8'h00),
		.analog_force(analog_mask),
		.pin_in(port_b_in),
		.drive_value(pb_drv),
		.drive_enable(pb_en),
		.pullup_on(pb_pull),
		.read_value(pb_rd)
	);

	gpio_pin_slice #(.W(7)) u_port_c (
		.latch(port_c_data_q),
		.direction(port_c_direction_q),
		.pullup_enable(port_c_pullup_enable_q),
		.analog_force(7'h00),
		.pin_in(port_c_in),
		.drive_value(pc_drv),
		.drive_enable(pc_en),
		.pullup_on(pc_pull),
		.read_value(pc_rd)
	);

	// ****************************************************************
	// APB slave
	// ****************************************************************
	// The access is taken once, at the first access-phase edge; the pready cycle that
	// follows must not act a second time.
	logic access_go;
	assign access_go = psel & penable & ~pready_q;

	function automatic logic addr_known(input logic [11:0] a);
		addr_known = (a == ADDR_PORT_B_DATA) || (a == ADDR_PORT_C_DATA) ||
			(a == ADDR_PORT_A_PULLUP_ENABLE) || (a == ADDR_PORT_B_DIRECTION) ||
			(a == ADDR_PORT_C_DIRECTION) || (a == ADDR_PORT_C_PULLUP_ENABLE) ||
			(a == ADDR_ANALOG_SELECT) || (a == ADDR_PORT_A_DIRECTION);
	endfunction

	always_comb
	begin
		state_d = state_q;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		port_b_data_d = port_b_data_q;
		port_c_data_d = port_c_data_q;
		port_a_pullup_enable_d = port_a_pullup_enable_q;
		port_b_direction_d = port_b_direction_q;
		port_c_direction_d = port_c_direction_q;
		port_c_pullup_enable_d = port_c_pullup_enable_q;
		case (state_q)
			st_idle:
			begin
				// One wait state: the access phase sees pready in its second cycle.
				if (psel & ~penable)
				begin
					state_d = st_access;
				end
			end
			st_access:
			begin
				if (access_go)
				begin
					// An unmapped address answers with an error and zero data and changes nothing.
					pready_d = 1'b1;
					pslverr_d = ~addr_known(paddr);
					prdata_d = 32'h0000_0000;
					// A write with the low byte strobe off is dropped without an error.
					if (pwrite & pstrb[0])
					begin
						case (paddr)
							ADDR_PORT_B_DATA: port_b_data_d = pwdata[7:0];
							ADDR_PORT_C_DATA: port_c_data_d = pwdata[6:0];
							ADDR_PORT_A_PULLUP_ENABLE: port_a_pullup_enable_d = pwdata[7:0];
							ADDR_PORT_B_DIRECTION: port_b_direction_d = pwdata[7:0];
							ADDR_PORT_C_DIRECTION: port_c_direction_d = pwdata[6:0];
							ADDR_PORT_C_PULLUP_ENABLE: port_c_pullup_enable_d = pwdata[6:0];
							default: port_b_data_d = port_b_data_q;
						endcase
					end
					// Input pins are read at their raw level at this edge; pins are taken as
					// synchronous to pclk, so no synchroniser stands in this path.
					if (~pwrite)
					begin
						case (paddr)
							ADDR_PORT_B_DATA: prdata_d = {24'h00_0000, pb_rd};
							ADDR_PORT_C_DATA: prdata_d = {25'h000_0000, pc_rd};
							ADDR_PORT_A_PULLUP_ENABLE: prdata_d = {24'h00_0000, port_a_pullup_enable_q};
							ADDR_PORT_B_DIRECTION: prdata_d = {24'h00_0000, port_b_direction_q};
							ADDR_PORT_C_DIRECTION: prdata_d = {25'h000_0000, port_c_direction_q};
							ADDR_PORT_C_PULLUP_ENABLE: prdata_d = {25'h000_0000, port_c_pullup_enable_q};
							ADDR_PORT_A_DIRECTION: prdata_d = {24'h00_0000, port_a_direction};
							ADDR_ANALOG_SELECT: prdata_d = {27'h000_0000, analog_channel};
							default: prdata_d = 32'h0000_0000;
						endcase
					end
				end
				else if (pready_q | ~psel)
				begin
					// A finished or abandoned access frees the slave for the next setup cycle.
					state_d = st_idle;
				end
			end
			default: state_d = st_idle;
		endcase
	end

	// ****************************************************************
	// Clocked state
	// ****************************************************************
	// Data latches: no reset branch, so reset leaves them untouched.
	always_ff @(posedge pclk)
	begin
		if (clk_en)
		begin
			port_b_data_q <= port_b_data_d;
			port_c_data_q <= port_c_data_d;
		end
	end

	// Bus response and handshake state.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= st_idle;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			state_q <= state_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	// Direction and pullup registers come out of reset as inputs without pullups.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			port_a_pullup_enable_q <= PULLUP_RESET;
			port_b_direction_q <= DIRECTION_RESET;
			port_c_direction_q <= DIRECTION_RESET[6:0];
			port_c_pullup_enable_q <= PULLUP_RESET[6:0];
		end
		else if (clk_en)
		begin
			port_a_pullup_enable_q <= port_a_pullup_enable_d;
			port_b_direction_q <= port_b_direction_d;
			port_c_direction_q <= port_c_direction_d;
			port_c_pullup_enable_q <= port_c_pullup_enable_d;
		end
	end

	// Pin controls are registered once more so that every pin output comes from a flop.
	// The price is one cycle of lag between a register write and the pin.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pa_pull_q <= 8'h00;
			pb_out_q <= 8'h00;
			pb_oe_q <= 8'h00;
			pb_ana_q <= 8'h00;
			pc_out_q <= 7'h00;
			pc_oe_q <= 7'h00;
			pc_pull_q <= 7'h00;
		end
		else if (clk_en)
		begin
			pa_pull_q <= pa_pull;
			pb_out_q <= pb_drv;
			pb_oe_q <= pb_en;
			pb_ana_q <= analog_mask;
			pc_out_q <= pc_drv;
			pc_oe_q <= pc_en;
			pc_pull_q <= pc_pull;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign port_a_pullup_on = pa_pull_q;
	assign port_b_out = pb_out_q;
	assign port_b_oe = pb_oe_q;
	assign analog_channel_pins = pb_ana_q;
	assign port_c_out = pc_out_q;
	assign port_c_oe = pc_oe_q;
	assign port_c_pullup_on = pc_pull_q;

	// ****************************************************************
	// Unused inputs and slice outputs
	// ****************************************************************
	// Gathered into one unread net so that leaving them open stays a visible choice.
	logic unused_ok;
	assign unused_ok = ^{pa_drv, pa_en, pa_rd, pb_pull, pwdata[31:8], pstrb[3:1]};

endmodule

// >>> testbench/gpio_ports_a_b_c_assertions.sv
// Checker of the GPIO block's port-level behaviour.
`timescale 1ns/1ns
module gpio_ports_a_b_c_assertions
	import gpio_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic [4:0] analog_channel,
	input wire logic [7:0] port_a_direction,
	input wire logic [7:0] port_a_pullup_on,
	input wire logic [7:0] port_b_oe,
	input wire logic [7:0] analog_channel_pins,
	input wire logic [6:0] port_c_oe,
	input wire logic [6:0] port_c_pullup_on
);
	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_pa_pullup_gate: assert property ($past(clk_en) && $past(presetn) |->
		(port_a_pullup_on & $past(port_a_direction)) == 8'h00) else $error("pullup on output");
	a_analog_force: assert property ($past(clk_en) && $past(presetn) |->
		analog_channel_pins == (($past(analog_channel) < 5'h08) ?
		(8'h01 << $past(analog_channel[2:0])) : 8'h00)) else $error("analog select wrong");
	a_b_oe_mask: assert property ((port_b_oe & analog_channel_pins) == 8'h00)
		else $error("analog pin driven");
	a_b_oe_hold: assert property (!$past(psel) && $past(presetn) &&
		$stable(analog_channel_pins) |-> $stable(port_b_oe)) else $error("driver moved");
	a_dir_reset: assert property ($rose(presetn) |-> port_b_oe == 8'h00 &&
		port_c_oe == 7'h00) else $error("driver on after reset");
	a_c_pullup_gate: assert property ((port_c_pullup_on & port_c_oe) == 7'h00)
		else $error("port c pullup on output");
	a_access_answer: assert property (psel && penable && !pready && clk_en |=> pready)
		else $error("no answer");
	a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
	a_read_upper: assert property (pready |-> prdata[31:8] == 24'h00_0000)
		else $error("upper bits set");
	a_error_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error data");

	cover property (pready && pslverr);
	cover property (analog_channel_pins != 8'h00);
	cover property (port_a_pullup_on != 8'h00);
endmodule

bind gpio_ports_a_b_c gpio_ports_a_b_c_assertions u_chk (.pclk, .presetn, .clk_en, .psel,
	.penable, .prdata, .pready, .pslverr, .analog_channel, .port_a_direction,
	.port_a_pullup_on, .port_b_oe, .analog_channel_pins, .port_c_oe, .port_c_pullup_on);

// >>> testbench/gpio_pin_model.sv
// Model of the pins around ports B and C and what drives them from outside.
`timescale 1ns/1ns
module gpio_pin_model
(
	// From the block
	input wire logic [7:0] port_b_out,
	input wire logic [7:0] port_b_oe,
	input wire logic [6:0] port_c_out,
	input wire logic [6:0] port_c_oe,
	input wire logic [6:0] port_c_pullup_on,
	// Outside drive
	input wire logic [7:0] ext_b,
	input wire logic [6:0] ext_c,
	// Pin levels
	output logic [7:0] port_b_in,
	output logic [6:0] port_c_in
);
	// Port B has no pullup, so an undriven pin shows only the outside level.
	assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & ext_b);
	assign port_c_in = (port_c_oe & port_c_out) | (~port_c_oe &
		(port_c_pullup_on | ext_c));
endmodule

// >>> testbench/gpio_ports_a_b_c_tb_top.sv
// Self-checking testbench of the GPIO block.
`timescale 1ns/1ns
module gpio_ports_a_b_c_tb_top
	import gpio_pkg::*;
;
	typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] x; logic e;} row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, clk_en;
	logic [3:0] pstrb;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0] analog_channel;
	logic [7:0] port_a_direction, port_a_pullup_on, port_b_in, port_b_out, port_b_oe;
	logic [7:0] analog_channel_pins, ext_b;
	logic [6:0] port_c_in, port_c_out, port_c_oe, port_c_pullup_on, ext_c;
	int n_mismatch, n_tests;
	row_t rows [19];

	gpio_ports_a_b_c u_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .analog_channel, .port_a_direction,
		.port_a_pullup_on, .port_b_in, .port_b_out, .port_b_oe, .analog_channel_pins,
		.port_c_in, .port_c_out, .port_c_oe, .port_c_pullup_on);
	gpio_pin_model u_pins (.port_b_out, .port_b_oe, .port_c_out, .port_c_oe,
		.port_c_pullup_on, .ext_b, .ext_c, .port_b_in, .port_c_in);

	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task conclude;
		if (n_mismatch == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk(input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16)
		begin
			n_mismatch++;
			conclude();
		end
	endtask

	task settle;
		repeat (2) @(posedge pclk);
		#1;
	endtask

	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial
	begin
		n_mismatch = 0;
		n_tests = 0;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		analog_channel = 5'h1f;
		clk_en = 1'b1;
		pstrb = 4'hf;
		port_a_direction = 8'h0f;
		ext_b = 8'ha5;
		// Port C bits 5 and 6 stay grounded inputs, as the small package needs.
		ext_c = 7'h0a;
		rows = '{'{0, ADDR_PORT_B_DIRECTION, 0, 0, 0}, '{0, ADDR_PORT_C_DIRECTION, 0, 0, 0},
			'{0, ADDR_PORT_A_PULLUP_ENABLE, 0, 0, 0},
			'{1, ADDR_PORT_B_DATA, 8'h3c, 0, 0},
			'{1, ADDR_PORT_B_DIRECTION, 8'h0f, 0, 0}, '{0, ADDR_PORT_B_DATA, 0, 8'hac, 0},
			'{1, ADDR_PORT_B_DATA, 8'hc3, 0, 0}, '{0, ADDR_PORT_B_DATA, 0, 8'ha3, 0},
			'{0, ADDR_PORT_B_DIRECTION, 0, 8'h0f, 0},
			'{1, ADDR_PORT_A_PULLUP_ENABLE, 8'hff, 0, 0},
			'{0, ADDR_PORT_A_PULLUP_ENABLE, 0, 8'hff, 0},
			'{1, ADDR_PORT_C_DATA, 8'h55, 0, 0},
			'{1, ADDR_PORT_C_DIRECTION, 8'h0f, 0, 0},
			'{1, ADDR_PORT_C_PULLUP_ENABLE, 8'h10, 0, 0},
			'{0, ADDR_PORT_C_DATA, 0, 8'h15, 0}, '{0, ADDR_PORT_A_DIRECTION, 0, 8'h0f, 0},
			'{0, ADDR_ANALOG_SELECT, 0, 8'h1f, 0},
			'{1, 12'h0fc, 8'h01, 0, 1}, '{0, 12'h0fc, 0, 0, 1}};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[k])
		begin
			apb(rows[k].w, rows[k].a, 32'(rows[k].d));
			if (!rows[k].w)
				chk(rd, 32'(rows[k].x));
			chk(32'(er), 32'(rows[k].e));
		end
		settle();
		chk(32'(port_b_oe), 32'h0000_000f);
		chk(32'(port_b_out), 32'h0000_00c3);
		chk(32'(port_a_pullup_on), 32'h0000_00f0);
		chk(32'(port_c_pullup_on), 32'h0000_0010);
		chk(32'(port_c_out), 32'h0000_0055);
		chk(32'(port_c_oe), 32'h0000_000f);
		@(posedge pclk);
		analog_channel <= 5'h02;
		port_a_direction <= 8'hff;
		settle();
		chk(32'(analog_channel_pins), 32'h0000_0004);
		chk(32'(port_b_oe), 32'h0000_000b);
		chk(32'(port_a_pullup_on), 32'h0000_0000);
		@(posedge pclk);
		presetn <= 1'b0;
		analog_channel <= 5'h1f;
		settle();
		chk(32'({port_b_oe, port_c_oe}), 32'h0000_0000);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, ADDR_PORT_B_DIRECTION, 32'h0000_00ff);
		apb(1'b0, ADDR_PORT_B_DATA, 32'h0000_0000);
		chk(rd, 32'h0000_00c3);
		apb(1'b1, ADDR_PORT_C_DIRECTION, 32'h0000_001f);
		apb(1'b0, ADDR_PORT_C_DATA, 32'h0000_0000);
		chk(rd, 32'h0000_0015);
		// A write with the low byte strobe off must leave the latch alone.
		@(posedge pclk);
		pstrb <= 4'he;
		apb(1'b1, ADDR_PORT_B_DATA, 32'h0000_0000);
		chk(32'(er), 32'h0000_0000);
		pstrb <= 4'hf;
		apb(1'b0, ADDR_PORT_B_DATA, 32'h0000_0000);
		chk(rd, 32'h0000_00c3);
		// With the clock enable low the analog select must not reach the pins.
		@(posedge pclk);
		clk_en <= 1'b0;
		analog_channel <= 5'h05;
		settle();
		chk(32'(analog_channel_pins), 32'h0000_0000);
		@(posedge pclk);
		clk_en <= 1'b1;
		settle();
		chk(32'(analog_channel_pins), 32'h0000_0020);
		chk(32'(port_b_oe), 32'h0000_00df);
		conclude();
	end
endmodule
